// ### hb_timing_pkg.sv
// Package of offsets, field layouts, reset values and timing for the half-bridge timing bank
// Operation
// - Initial-current register holds discharge code 15:10 and charge code 9:4 per bridge.
// - Power-on reset loads discharge codes 001111 and charge codes 001101 everywhere.
// - Initial-current bank index 2:0 selects bridge one to four; 000 after reset.
// - Initial-current index 1xx is invalid; controller avoids it, device writes no bridge and reads the last valid one.
// - Initial-current bit 3 is read-only and always reads zero.
// - Initial-current register resets to 0x3CD0 and sits at address 001 1010.
// - Restart clears initial-current low four bits, keeps bits 15:4.
// - Turn-on register holds 6-bit code at 13:8; bits 15:14 and 7:3 read zero.
// - Turn-on delay applied equals code times 53.3 ns.
// - Turn-on bank index 2:0 selects bridge one to four, bridge one by default.
// - Turn-on index 1xx is invalid; controller avoids writing it.
// - Turn-off register holds code at 13:8, zero reserved bits, address 001 1100.
// - Turn-off delay applied equals code times 53.3 ns, default 640 ns.
// - Turn-off bank index 2:0 selects bridge one to four, bridge one by default.
// - Turn-off index 1xx is invalid; controller avoids writing it.
// - Power-on reset sets both delay registers to 0x0C00.
// - Restart clears delay registers bits 15:14 and 7:0, keeps delay codes.
package hb_timing_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_INIT_CURRENT = 7'h1a;
  localparam logic [6:0] ADDR_TURN_ON = 7'h1b;
  localparam logic [6:0] ADDR_TURN_OFF = 7'h1c;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int CODE_W = 6;
  localparam int IDX_MSB = 2;
  localparam int IDX_LSB = 0;
  localparam int RO_ZERO_BIT = 3;
  localparam int DCHG_MSB = 15;
  localparam int DCHG_LSB = 10;
  localparam int CHG_MSB = 9;
  localparam int CHG_LSB = 4;
  localparam int DLY_MSB = 13;
  localparam int DLY_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_INIT_REG = 16'h3cd0;
  localparam logic [15:0] RST_DELAY_REG = 16'h0c00;
  localparam logic [5:0] RST_DCHG_CODE = 6'h0f;
  localparam logic [5:0] RST_CHG_CODE = 6'h0d;
  localparam logic [5:0] RST_DELAY_CODE = 6'h0c;
  localparam logic [2:0] RST_IDX = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam real DELAY_STEP_NS = 53.3;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam int DELAY_STEP_PS = int'(DELAY_STEP_NS * 1000.0);
  localparam int CLK_PERIOD_PS = int'(CLK_PERIOD_NS * 1000.0);
  localparam int CNT_W = 10;

  // Nominal delay rounded up to whole clock cycles
  function automatic logic [CNT_W-1:0] delay_cycles(input logic [CODE_W-1:0] code);
    int ps;
    ps = int'(code) * DELAY_STEP_PS;
    return CNT_W'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : delay_cycles

  function automatic logic idx_valid(input logic [2:0] idx);
    return ~idx[2];
  endfunction : idx_valid

endpackage : hb_timing_pkg

// ### bank_if.sv
// Interface between the register front end and one banked code store
`timescale 1ns/1ps
interface bank_if #(
  parameter int W = 6
);
  logic we;
  logic [1:0] idx;
  logic [W-1:0] wdata;
  logic [3:0][W-1:0] codes;

  modport ctrl(output we, output idx, output wdata, input codes);
  modport store(input we, input idx, input wdata, output codes);
endinterface : bank_if

// ### bank_store.sv
// Four-entry banked code store, one entry per half-bridge
`timescale 1ns/1ps
module bank_store #(
  parameter int W = 6,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Access
  bank_if.store bus
);

  typedef struct packed {
    logic [3:0][W-1:0] entry;
  } store_t;

  store_t st_ff;
  store_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (bus.we) begin
      nxt_st.entry[bus.idx] = bus.wdata;
    end
  end

  // Restart never reaches here, so stored codes survive it
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= {4{RESET_VAL}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.codes = st_ff.entry;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_store_write_lands: assert property (bus.we |=> st_ff.entry[$past(bus.idx)] == $past(bus.wdata))
    else $error("Banked write did not land");
  a_store_idle_holds: assert property (!bus.we |=> $stable(st_ff.entry))
    else $error("Banked codes changed without a write");

endmodule : bank_store

// ### switch_delay.sv
// Turn-on and turn-off delay of the active transistor for one half-bridge
`timescale 1ns/1ps
module switch_delay (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Command and codes
  input wire logic i_cmd,
  input wire logic [5:0] i_on_code,
  input wire logic [5:0] i_off_code,
  // Delayed drive
  output logic o_drive
);

  typedef struct packed {
    logic drive;
    logic pend;
    logic [hb_timing_pkg::CNT_W-1:0] cnt;
  } dly_t;

  dly_t st_ff;
  dly_t nxt_st;

  // A command that flips back before expiry is dropped as a glitch
  always_comb begin
    nxt_st = st_ff;
    if (i_cmd == st_ff.drive) begin
      nxt_st.pend = 1'b0;
    end else if (!st_ff.pend) begin
      nxt_st.pend = 1'b1;
      nxt_st.cnt = i_cmd ? hb_timing_pkg::delay_cycles(i_on_code)
                         : hb_timing_pkg::delay_cycles(i_off_code);
    end else if (st_ff.cnt == '0) begin
      nxt_st.drive = i_cmd;
      nxt_st.pend = 1'b0;
    end else begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_drive = st_ff.drive;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_delay_on_hold: assert property (st_ff.pend && st_ff.cnt != '0 |=> $stable(st_ff.drive))
    else $error("Drive changed before delay expired");
  a_delay_load: assert property (!st_ff.pend && i_cmd && !st_ff.drive
      |=> st_ff.cnt == hb_timing_pkg::delay_cycles($past(i_on_code)))
    else $error("Turn-on count not loaded from code");
  a_delay_off_load: assert property (!st_ff.pend && !i_cmd && st_ff.drive
      |=> st_ff.cnt == hb_timing_pkg::delay_cycles($past(i_off_code)))
    else $error("Turn-off count not loaded from code");

endmodule : switch_delay

// ### hb_timing_bank_regs.sv
// Banked turn-on, turn-off and initial-current registers for four half-bridges
`timescale 1ns/1ps
module hb_timing_bank_regs (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  // Register access from the frame decoder
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic [6:0] i_acc_addr,
  input wire logic [15:0] i_acc_wdata,
  output logic o_acc_rvalid,
  output logic [15:0] o_acc_rdata,
  // Gate driver side
  input wire logic [3:0] i_gate_cmd,
  output logic [3:0] o_gate_drive,
  output logic [23:0] o_turn_on_delay_code,
  output logic [23:0] o_turn_off_delay_code,
  output logic [23:0] o_init_charge_current_code,
  output logic [23:0] o_init_discharge_current_code
);

  typedef struct packed {
    logic [2:0] init_current_bank_select;
    logic [2:0] turn_on_bank_select;
    logic [2:0] turn_off_bank_select;
    logic [1:0] init_bank;
    logic [1:0] on_bank;
    logic [1:0] off_bank;
    logic rvalid;
    logic [15:0] rdata;
  } regs_t;

  regs_t st_ff;
  regs_t nxt_st;

  bank_if #(.W(6)) on_bus();
  bank_if #(.W(6)) off_bus();
  bank_if #(.W(12)) init_bus();

  // ---------------------------------------------------------------
  // Code stores
  // ---------------------------------------------------------------
  bank_store #(
    .W(6),
    .RESET_VAL(hb_timing_pkg::RST_DELAY_CODE)
  ) u_on_store (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .bus(on_bus.store)
  );

  bank_store #(
    .W(6),
    .RESET_VAL(hb_timing_pkg::RST_DELAY_CODE)
  ) u_off_store (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .bus(off_bus.store)
  );

  bank_store #(
    .W(12),
    .RESET_VAL({hb_timing_pkg::RST_DCHG_CODE, hb_timing_pkg::RST_CHG_CODE})
  ) u_init_store (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .bus(init_bus.store)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Effective bank: the access index if valid, else the last valid one
  function automatic logic [1:0] pick_bank(input logic [2:0] idx, input logic [1:0] last);
    return hb_timing_pkg::idx_valid(idx) ? idx[1:0] : last;
  endfunction : pick_bank

  function automatic logic [15:0] delay_word(input logic [5:0] code, input logic [2:0] idx);
    logic [15:0] w;
    w = '0;
    w[hb_timing_pkg::DLY_MSB:hb_timing_pkg::DLY_LSB] = code;
    w[hb_timing_pkg::IDX_MSB:hb_timing_pkg::IDX_LSB] = idx;
    return w;
  endfunction : delay_word

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic [2:0] acc_idx;
  logic [1:0] acc_bank;
  logic [5:0] dchg_w;
  logic [5:0] chg_w;
  logic [5:0] dly_w;

  assign acc_idx = i_acc_wdata[hb_timing_pkg::IDX_MSB:hb_timing_pkg::IDX_LSB];
  assign dchg_w = i_acc_wdata[hb_timing_pkg::DCHG_MSB:hb_timing_pkg::DCHG_LSB];
  assign chg_w = i_acc_wdata[hb_timing_pkg::CHG_MSB:hb_timing_pkg::CHG_LSB];
  assign dly_w = i_acc_wdata[hb_timing_pkg::DLY_MSB:hb_timing_pkg::DLY_LSB];

  always_comb begin
    logic [2:0] idx;
    logic [11:0] ic;
    logic [5:0] dc;
    idx = '0;
    ic = '0;
    dc = '0;
    acc_bank = '0;
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    on_bus.we = 1'b0;
    on_bus.idx = '0;
    on_bus.wdata = dly_w;
    off_bus.we = 1'b0;
    off_bus.idx = '0;
    off_bus.wdata = dly_w;
    init_bus.we = 1'b0;
    init_bus.idx = '0;
    init_bus.wdata = {dchg_w, chg_w};
    if (i_restart) begin
      // Restart wins over a coinciding access; only index fields clear
      nxt_st.init_current_bank_select = hb_timing_pkg::RST_IDX;
      nxt_st.init_bank = '0;
      nxt_st.turn_on_bank_select = hb_timing_pkg::RST_IDX;
      nxt_st.on_bank = '0;
      nxt_st.turn_off_bank_select = hb_timing_pkg::RST_IDX;
      nxt_st.off_bank = '0;
    end else if (i_acc_valid && i_acc_addr == hb_timing_pkg::ADDR_INIT_CURRENT) begin
      idx = i_acc_write ? acc_idx : st_ff.init_current_bank_select;
      acc_bank = pick_bank(idx, st_ff.init_bank);
      init_bus.idx = acc_bank;
      init_bus.we = i_acc_write && hb_timing_pkg::idx_valid(acc_idx);
      ic = init_bus.we ? {dchg_w, chg_w} : init_bus.codes[acc_bank];
      if (i_acc_write) begin
        nxt_st.init_current_bank_select = acc_idx;
        nxt_st.init_bank = acc_bank;
      end
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = {ic, 1'b0, idx};
    end else if (i_acc_valid && i_acc_addr == hb_timing_pkg::ADDR_TURN_ON) begin
      idx = i_acc_write ? acc_idx : st_ff.turn_on_bank_select;
      acc_bank = pick_bank(idx, st_ff.on_bank);
      on_bus.idx = acc_bank;
      on_bus.we = i_acc_write && hb_timing_pkg::idx_valid(acc_idx);
      dc = on_bus.we ? dly_w : on_bus.codes[acc_bank];
      if (i_acc_write) begin
        nxt_st.turn_on_bank_select = acc_idx;
        nxt_st.on_bank = acc_bank;
      end
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = delay_word(dc, idx);
    end else if (i_acc_valid && i_acc_addr == hb_timing_pkg::ADDR_TURN_OFF) begin
      idx = i_acc_write ? acc_idx : st_ff.turn_off_bank_select;
      acc_bank = pick_bank(idx, st_ff.off_bank);
      off_bus.idx = acc_bank;
      off_bus.we = i_acc_write && hb_timing_pkg::idx_valid(acc_idx);
      dc = off_bus.we ? dly_w : off_bus.codes[acc_bank];
      if (i_acc_write) begin
        nxt_st.turn_off_bank_select = acc_idx;
        nxt_st.off_bank = acc_bank;
      end
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = delay_word(dc, idx);
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_acc_rvalid = st_ff.rvalid;
  assign o_acc_rdata = st_ff.rdata;

  // ---------------------------------------------------------------
  // Gate driver side
  // ---------------------------------------------------------------
  assign o_turn_on_delay_code = on_bus.codes;
  assign o_turn_off_delay_code = off_bus.codes;

  for (genvar b = 0; b < 4; b++) begin : g_bridge
    assign o_init_charge_current_code[b*6 +: 6] = init_bus.codes[b][5:0];
    assign o_init_discharge_current_code[b*6 +: 6] = init_bus.codes[b][11:6];

    switch_delay u_delay (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_cmd(i_gate_cmd[b]),
      .i_on_code(on_bus.codes[b]),
      .i_off_code(off_bus.codes[b]),
      .o_drive(o_gate_drive[b])
    );
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_ro_bit_zero: assert property (o_acc_rvalid |-> o_acc_rdata[3] == 1'b0)
    else $error("Read-only bit 3 read as one");

  a_delay_reserved_zero: assert property (
      i_acc_valid && !i_restart
      && (i_acc_addr == hb_timing_pkg::ADDR_TURN_ON || i_acc_addr == hb_timing_pkg::ADDR_TURN_OFF)
      |=> o_acc_rvalid && o_acc_rdata[15:14] == 2'h0 && o_acc_rdata[7:3] == 5'h00)
    else $error("Reserved delay bits not zero");

  a_restart_clears_index: assert property (i_restart
      |=> st_ff.init_current_bank_select == 3'h0
      && st_ff.turn_on_bank_select == 3'h0 && st_ff.turn_off_bank_select == 3'h0)
    else $error("Restart left a bank index set");

  a_restart_keeps_codes: assert property (i_restart |=> $stable(init_bus.codes)
      && $stable(on_bus.codes) && $stable(off_bus.codes))
    else $error("Restart changed stored codes");

  a_invalid_write_ignored: assert property (i_acc_valid && i_acc_write && acc_idx[2]
      |=> $stable(init_bus.codes) && $stable(on_bus.codes) && $stable(off_bus.codes))
    else $error("Invalid bank write changed a code");

  a_init_write_lands: assert property (
      i_acc_valid && i_acc_write && !i_restart && !acc_idx[2]
      && i_acc_addr == hb_timing_pkg::ADDR_INIT_CURRENT
      |=> o_init_charge_current_code[$past(acc_idx[1:0])*6 +: 6] == $past(chg_w)
      && o_init_discharge_current_code[$past(acc_idx[1:0])*6 +: 6] == $past(dchg_w))
    else $error("Initial current codes not stored to selected bridge");

  a_read_follows_bank: assert property (
      i_acc_valid && !i_acc_write && !i_restart
      && i_acc_addr == hb_timing_pkg::ADDR_TURN_ON
      |=> o_acc_rdata[13:8] == o_turn_on_delay_code[$past(acc_bank)*6 +: 6])
    else $error("Turn-on read returned wrong bridge");

  a_unmapped_silent: assert property (
      i_acc_valid && i_acc_addr != hb_timing_pkg::ADDR_INIT_CURRENT
      && i_acc_addr != hb_timing_pkg::ADDR_TURN_ON && i_acc_addr != hb_timing_pkg::ADDR_TURN_OFF
      |=> !o_acc_rvalid)
    else $error("Answer given for unmapped address");

  a_reset_codes: assert property ($rose(i_rst_n) |-> o_turn_on_delay_code[5:0] == 6'h0c
      && o_init_discharge_current_code[5:0] == 6'h0f && o_init_charge_current_code[5:0] == 6'h0d)
    else $error("Power-on codes wrong");

  // ---------------------------------------------------------------
  // Access and store checks
  // ---------------------------------------------------------------
  // Accesses the decoder takes; restart and unmapped ones excluded
  logic take_init;
  logic take_on;
  logic take_off;

  assign take_init = i_acc_valid && !i_restart && i_acc_addr == hb_timing_pkg::ADDR_INIT_CURRENT;
  assign take_on = i_acc_valid && !i_restart && i_acc_addr == hb_timing_pkg::ADDR_TURN_ON;
  assign take_off = i_acc_valid && !i_restart && i_acc_addr == hb_timing_pkg::ADDR_TURN_OFF;

  a_answer_follows_take: assert property (
      take_init || take_on || take_off
      |=> o_acc_rvalid)
    else $error("Taken access got no answer");

  a_idle_no_answer: assert property (
      !i_acc_valid
      |=> !o_acc_rvalid)
    else $error("Answer given without an access");

  a_restart_drops_access: assert property (
      i_restart
      |=> !o_acc_rvalid)
    else $error("Access answered during restart");

  a_write_index_echo: assert property (
      (take_init || take_on || take_off) && i_acc_write
      |=> o_acc_rdata[2:0] == $past(acc_idx))
    else $error("Write answer lost its bank index");

  a_on_read_index: assert property (
      take_on && !i_acc_write
      |=> o_acc_rdata[2:0] == $past(st_ff.turn_on_bank_select))
    else $error("Turn-on read lost its bank index");

  a_off_read_follows: assert property (
      take_off && !i_acc_write
      |=> o_acc_rdata[13:8] == o_turn_off_delay_code[$past(acc_bank)*6 +: 6])
    else $error("Turn-off read returned wrong bridge");

  a_init_read_follows: assert property (
      take_init && !i_acc_write
      |=> o_acc_rdata[15:10] == o_init_discharge_current_code[$past(acc_bank)*6 +: 6]
      && o_acc_rdata[9:4] == o_init_charge_current_code[$past(acc_bank)*6 +: 6])
    else $error("Initial current read returned wrong bridge");

  a_on_write_lands: assert property (
      take_on && i_acc_write && !acc_idx[2]
      |=> o_turn_on_delay_code[$past(acc_idx[1:0])*6 +: 6] == $past(dly_w))
    else $error("Turn-on code not stored to selected bridge");

  a_off_write_lands: assert property (
      take_off && i_acc_write && !acc_idx[2]
      |=> o_turn_off_delay_code[$past(acc_idx[1:0])*6 +: 6] == $past(dly_w))
    else $error("Turn-off code not stored to selected bridge");

  a_init_select_stored: assert property (
      take_init && i_acc_write
      |=> st_ff.init_current_bank_select == $past(acc_idx))
    else $error("Initial current index not stored");

  a_on_select_stored: assert property (
      take_on && i_acc_write
      |=> st_ff.turn_on_bank_select == $past(acc_idx))
    else $error("Turn-on index not stored");

  a_off_select_stored: assert property (
      take_off && i_acc_write
      |=> st_ff.turn_off_bank_select == $past(acc_idx))
    else $error("Turn-off index not stored");

  a_init_last_valid: assert property (
      take_init && i_acc_write && acc_idx[2]
      |=> $stable(st_ff.init_bank))
    else $error("Invalid index moved the initial current bridge");

  a_no_take_holds: assert property (
      !(take_init || take_on || take_off)
      |=> $stable(on_bus.codes) && $stable(off_bus.codes) && $stable(init_bus.codes))
    else $error("Codes changed without a taken write");

  // ---------------------------------------------------------------
  // Reset checks
  // ---------------------------------------------------------------
  a_restart_clears_bank: assert property (
      i_restart
      |=> st_ff.init_bank == 2'h0 && st_ff.on_bank == 2'h0 && st_ff.off_bank == 2'h0)
    else $error("Restart left a last valid bridge set");

  a_reset_delay_codes: assert property (
      $rose(i_rst_n)
      |-> o_turn_on_delay_code == {4{hb_timing_pkg::RST_DELAY_CODE}}
      && o_turn_off_delay_code == {4{hb_timing_pkg::RST_DELAY_CODE}})
    else $error("Power-on delay codes wrong");

  a_reset_init_codes: assert property (
      $rose(i_rst_n)
      |-> o_init_charge_current_code == {4{hb_timing_pkg::RST_CHG_CODE}}
      && o_init_discharge_current_code == {4{hb_timing_pkg::RST_DCHG_CODE}})
    else $error("Power-on current codes wrong");

  a_reset_index_zero: assert property (
      $rose(i_rst_n)
      |-> st_ff.init_current_bank_select == 3'h0 && st_ff.turn_on_bank_select == 3'h0
      && st_ff.turn_off_bank_select == 3'h0)
    else $error("Power-on bank index not zero");

endmodule : hb_timing_bank_regs

// ### mcu_access_model.sv
// Controller model that issues register read and write accesses
`timescale 1ns/1ps
module mcu_access_model (
  // Clock
  input wire logic i_core_clk,
  // Access request
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic [6:0] o_acc_addr,
  output logic [15:0] o_acc_wdata,
  // Answer
  input wire logic i_acc_rvalid,
  input wire logic [15:0] i_acc_rdata
);
  // Idle address is unmapped so a stray strobe cannot hit a register
  initial begin
    o_acc_valid = 1'b0;
    o_acc_write = 1'b0;
    o_acc_addr = 7'h7f;
    o_acc_wdata = 16'hffff;
  end

  // ---------------------------------------------------------------
  // One whole 16-bit access per call
  // ---------------------------------------------------------------
  task automatic access(input logic wr, input logic [6:0] addr, input logic [15:0] data,
                        output logic rv, output logic [15:0] rd);
    @(posedge i_core_clk);
    o_acc_valid <= 1'b1;
    o_acc_write <= wr;
    o_acc_addr <= addr;
    o_acc_wdata <= data;
    @(posedge i_core_clk);
    // Released lines show the inverse, never a stale copy
    o_acc_valid <= 1'b0;
    o_acc_write <= ~wr;
    o_acc_addr <= ~addr;
    o_acc_wdata <= ~data;
    #1;
    rv = i_acc_rvalid;
    rd = i_acc_rdata;
  endtask : access
endmodule : mcu_access_model

// ### hb_timing_bank_regs_bench.sv
// Self-checking bench for the banked half-bridge timing registers
`timescale 1ns/1ps
module hb_timing_bank_regs_bench;
  logic i_core_clk;
  logic i_rst_n;
  logic i_restart;
  logic [3:0] gate_cmd;
  logic acc_valid, acc_write, rvalid;
  logic [6:0] acc_addr;
  logic [15:0] acc_wdata, rdata;
  logic [3:0] gate_drive;
  logic [23:0] on_v, off_v, chg_v, dchg_v;
  logic [5:0] on_e [4];
  logic [5:0] off_e [4];
  logic [5:0] chg_e [4];
  logic [5:0] dchg_e [4];
  logic rv;
  logic [15:0] rd;
  logic [2:0] ix;
  int fails, n_tests, b;
  localparam logic [6:0] A_INIT = hb_timing_pkg::ADDR_INIT_CURRENT;
  localparam logic [6:0] A_ON = hb_timing_pkg::ADDR_TURN_ON;
  localparam logic [6:0] A_OFF = hb_timing_pkg::ADDR_TURN_OFF;

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  mcu_access_model mcu_access_model_i (
    .i_core_clk(i_core_clk), .o_acc_valid(acc_valid), .o_acc_write(acc_write),
    .o_acc_addr(acc_addr), .o_acc_wdata(acc_wdata), .i_acc_rvalid(rvalid), .i_acc_rdata(rdata)
  );

  hb_timing_bank_regs hb_timing_bank_regs_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_restart(i_restart),
    .i_acc_valid(acc_valid), .i_acc_write(acc_write), .i_acc_addr(acc_addr),
    .i_acc_wdata(acc_wdata), .o_acc_rvalid(rvalid), .o_acc_rdata(rdata),
    .i_gate_cmd(gate_cmd), .o_gate_drive(gate_drive), .o_turn_on_delay_code(on_v),
    .o_turn_off_delay_code(off_v), .o_init_charge_current_code(chg_v),
    .o_init_discharge_current_code(dchg_v)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] dly_w(input logic [5:0] code, input logic [2:0] idx);
    return {2'b00, code, 5'h00, idx};
  endfunction : dly_w

  function automatic logic [15:0] init_w(input int k, input logic [2:0] idx);
    return {dchg_e[k], chg_e[k], 1'b0, idx};
  endfunction : init_w

  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d,
                     input logic [15:0] exp);
    mcu_access_model_i.access(w, a, d, rv, rd);
    check({15'h0000, rv}, 16'h0001);
    check(rd, exp);
  endtask : acc

  task automatic chk_outs();
    for (int k = 0; k < 4; k++) begin
      check({10'h000, on_v[6*k+:6]}, {10'h000, on_e[k]});
      check({10'h000, off_v[6*k+:6]}, {10'h000, off_e[k]});
      check({10'h000, chg_v[6*k+:6]}, {10'h000, chg_e[k]});
      check({10'h000, dchg_v[6*k+:6]}, {10'h000, dchg_e[k]});
    end
  endtask : chk_outs

  // Allows one edge of slack on the landing edge of the delayed drive
  task automatic gate(input logic lvl, input logic [5:0] code);
    int n;
    n = (int'(code) * 53300 + 3999) / 4000;
    @(posedge i_core_clk);
    gate_cmd[0] <= lvl;
    repeat (n + 1) @(posedge i_core_clk);
    #1;
    check({15'h0000, gate_drive[0]}, {15'h0000, ~lvl});
    repeat (2) @(posedge i_core_clk);
    #1;
    check({15'h0000, gate_drive[0]}, {15'h0000, lvl});
    check({13'h0000, gate_drive[3:1]}, 16'h0000);
  endtask : gate

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    #100000;
    fails++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_restart = 1'b0;
    gate_cmd = 4'h0;
    fails = 0;
    n_tests = 0;
    for (int k = 0; k < 4; k++) begin
      on_e[k] = 6'h0c;
      off_e[k] = 6'h0c;
      chg_e[k] = 6'h0d;
      dchg_e[k] = 6'h0f;
    end
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1;
    chk_outs();
    acc(1'b0, A_INIT, 16'h0007, 16'h3cd0);
    acc(1'b0, A_ON, 16'h0002, 16'h0c00);
    acc(1'b0, A_OFF, 16'h0001, 16'h0c00);
    // Every bridge gets distinct codes; reserved and read-only bits are written as ones
    for (b = 0; b < 4; b++) begin
      ix = 3'(b);
      on_e[b] = 6'h10 + 6'(b);
      off_e[b] = 6'h20 + 6'(b);
      chg_e[b] = 6'h01 + 6'(b);
      dchg_e[b] = 6'h38 + 6'(b);
      acc(1'b1, A_ON, {2'b11, on_e[b], 5'h1f, ix}, dly_w(on_e[b], ix));
      acc(1'b1, A_OFF, {2'b11, off_e[b], 5'h1f, ix}, dly_w(off_e[b], ix));
      acc(1'b1, A_INIT, {dchg_e[b], chg_e[b], 1'b1, ix}, init_w(b, ix));
    end
    chk_outs();
    acc(1'b0, A_ON, 16'h0000, dly_w(on_e[3], 3'h3));
    // Invalid indices keep all codes; answer shows last valid bridge
    acc(1'b1, A_ON, 16'h3f04, dly_w(on_e[3], 3'h4));
    acc(1'b1, A_OFF, 16'h3f07, dly_w(off_e[3], 3'h7));
    acc(1'b1, A_INIT, 16'hfff5, init_w(3, 3'h5));
    chk_outs();
    acc(1'b0, A_ON, 16'h0000, dly_w(on_e[3], 3'h4));
    mcu_access_model_i.access(1'b0, 7'h1d, 16'h0000, rv, rd);
    check({15'h0000, rv}, 16'h0000);
    check(rd, dly_w(on_e[3], 3'h4));
    // Restart clears indices and reserved bits, keeps codes
    @(posedge i_core_clk);
    i_restart <= 1'b1;
    @(posedge i_core_clk);
    i_restart <= 1'b0;
    acc(1'b0, A_INIT, 16'h0003, init_w(0, 3'h0));
    acc(1'b0, A_ON, 16'h0003, dly_w(on_e[0], 3'h0));
    acc(1'b0, A_OFF, 16'h0003, dly_w(off_e[0], 3'h0));
    chk_outs();
    // Short codes on bridge one keep the delay checks brief
    on_e[0] = 6'h01;
    off_e[0] = 6'h02;
    acc(1'b1, A_ON, dly_w(6'h01, 3'h0), dly_w(6'h01, 3'h0));
    acc(1'b1, A_OFF, dly_w(6'h02, 3'h0), dly_w(6'h02, 3'h0));
    gate(1'b1, 6'h01);
    gate(1'b0, 6'h02);
    chk_outs();
    summarize();
  end
endmodule : hb_timing_bank_regs_bench
